// >>> bdg_pkg.sv
/*
  shared constants, register map and types for the bunch drive generator.
  assumes an apb master with 32-bit data and one clock for bus and datapath.
*/
`default_nettype none
package bdg_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_FREQ = 12'h004;
  localparam logic [11:0] OFS_AMPL = 12'h008;
  localparam logic [11:0] OFS_SPAN = 12'h00C;
  localparam logic [11:0] OFS_PER = 12'h010;
  localparam logic [11:0] OFS_ACT_FREQ = 12'h014;
  localparam logic [11:0] OFS_ACT_SPAN = 12'h018;
  localparam logic [11:0] OFS_ACT_PER = 12'h01C;
  localparam logic [11:0] OFS_STAT = 12'h020;
  localparam logic [11:0] OFS_MASK = 12'h040;
  // ----------------------------------------
  // widths, fields and reset values
  // ----------------------------------------
  localparam int PHASE_W = 30;
  localparam int AMP_W = 17;
  localparam int SMP_W = 16;
  localparam logic [AMP_W-1:0] AMP_FULL = 17'h08000;
  localparam logic [AMP_W-1:0] AMP_RST = 17'h00000;
  localparam logic [PHASE_W-1:0] FREQ_RST = 30'h00000000;
  localparam logic [SMP_W-1:0] FS_POS = 16'h7FFF;
  localparam logic [SMP_W-1:0] FS_NEG = 16'h8001;
  localparam int AMP_SHIFT = 15;
  localparam int IDX_W = 4;
  typedef enum logic [1:0] {WAVE_SINE, WAVE_SQUARE, WAVE_DC} bdg_wave_e;
  // quarter-wave sine table, midpoint sampled
  localparam logic [14:0] SINE_Q [16] = '{
    15'h0648, 15'h12C8, 15'h1F1A, 15'h2B1F, 15'h36BA, 15'h41CE, 15'h4C40, 15'h55F5,
    15'h5ED7, 15'h66CF, 15'h6DC9, 15'h73B5, 15'h7883, 15'h7C29, 15'h7E9C, 15'h7FD8};
  typedef struct packed {
    logic [7:0] bunch;
    logic [SMP_W-1:0] data;
  } bdg_sample_s;
endpackage
`default_nettype wire

// >>> bdg_drive_gen.sv
/*
  bunch drive generator: nco with sweep, waveform shaping, amplitude scale,
  per-bunch enable mask, two-entry output buffer and an apb register slave.
  assumes pclk is the bunch-rate clock and the dac side drains with ready.
*/
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
// Notes on behaviour
// R1 - nco tunes in steps of clock over two to the thirtieth, 30-bit accumulator
// R2 - output scaled by amplitude from zero to full scale one
// R3 - waveform select: sine, square or dc level
// R4 - sweeping only in sine or square; dc never swept
// R5 - zero span means fixed frequency, no modulation
// R6 - zero period also means fixed base frequency, no modulation
// R7 - loaded frequency word readable back as actual frequency
// R8 - span and period in effect readable, showing quantization
// R9 - enable mask picks which bunch slots get the drive
// R10 - mask writable by host and readable back for verification
// R11 - one independent enable bit per bunch, any subset allowed
// R12 - disabled bunch slots get zero drive
// R13 - sweep ramps linearly from base over span, restarts every period
`default_nettype none
module bdg_drive_gen
#(
  parameter int NUM_BUNCH = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic out_valid,
  input wire logic out_ready,
  output bdg_pkg::bdg_sample_s out_sample
);
  import bdg_pkg::*;
  localparam int MASK_WORDS = (NUM_BUNCH + 31) / 32;
  localparam logic [7:0] LAST_BUNCH = 8'(NUM_BUNCH - 1);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic [1:0] wave_reg;
  logic [PHASE_W-1:0] freq_reg;
  logic [AMP_W-1:0] ampl_reg;
  logic [PHASE_W-1:0] span_reg;
  logic [31:0] per_reg;
  logic [31:0] mask_mem [MASK_WORDS];
  logic [PHASE_W-1:0] act_span;
  logic [31:0] act_per;
  logic sweep_on;
  logic [7:0] bunch_reg;

  wire acc = psel && penable;
  wire in_mask = paddr >= OFS_MASK && paddr < OFS_MASK + 12'(MASK_WORDS * 4);
  wire [11:0] mask_ofs = paddr - OFS_MASK;
  wire [11:0] mask_idx = {2'h0, mask_ofs[11:2]};
  wire hit = in_mask || paddr == OFS_CTRL || paddr == OFS_FREQ || paddr == OFS_AMPL
    || paddr == OFS_SPAN || paddr == OFS_PER || paddr == OFS_ACT_FREQ
    || paddr == OFS_ACT_SPAN || paddr == OFS_ACT_PER || paddr == OFS_STAT;
  wire wr = acc && pwrite && hit;
  wire [AMP_W-1:0] amp_wr = (pwdata[AMP_W-1:0] > AMP_FULL) ? AMP_FULL : pwdata[AMP_W-1:0];
  wire [1:0] wave_wr = (pwdata[1:0] > 2'(WAVE_DC)) ? 2'(WAVE_DC) : pwdata[1:0];

  assign pready = 1'b1;
  assign pslverr = acc && !hit;

  always_comb begin
    prdata = 32'h00000000;
    if (in_mask) begin
      prdata = mask_mem[mask_idx[$clog2(MASK_WORDS)-1:0]]; // R10
    end else begin
      case (paddr)
        OFS_CTRL: prdata = {30'h0, wave_reg};
        OFS_FREQ: prdata = {2'h0, freq_reg};
        OFS_AMPL: prdata = {15'h0, ampl_reg};
        OFS_SPAN: prdata = {2'h0, span_reg};
        OFS_PER: prdata = per_reg;
        OFS_ACT_FREQ: prdata = {2'h0, freq_reg}; // R7
        OFS_ACT_SPAN: prdata = {2'h0, act_span}; // R8
        OFS_ACT_PER: prdata = act_per; // R8
        OFS_STAT: prdata = {23'h0, sweep_on, bunch_reg};
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // settings registers
  // ----------------------------------------
  // amplitude above one is clipped on write so the product cannot overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_reg <= 2'(WAVE_SINE);
      freq_reg <= FREQ_RST;
      ampl_reg <= AMP_RST;
      span_reg <= FREQ_RST;
      per_reg <= 32'h00000000;
    end else if (wr) begin
      if (paddr == OFS_CTRL) wave_reg <= wave_wr; // R3
      if (paddr == OFS_FREQ) freq_reg <= pwdata[PHASE_W-1:0];
      if (paddr == OFS_AMPL) ampl_reg <= amp_wr; // R2
      if (paddr == OFS_SPAN) span_reg <= pwdata[PHASE_W-1:0];
      if (paddr == OFS_PER) per_reg <= pwdata;
    end
  end

  // mask has no reset: software loads it before enabling drive
  always_ff @(posedge pclk) begin
    if (wr && in_mask) begin
      mask_mem[mask_idx[$clog2(MASK_WORDS)-1:0]] <= pwdata; // R10 R11
    end
  end

  // ----------------------------------------
  // sweep
  // ----------------------------------------
  // span register is the per-sample frequency increment, so the real span
  // is increment times period, truncated to the nco word
  logic [PHASE_W-1:0] sw_ofs_reg;
  logic [31:0] sw_cnt_reg;
  logic adv;
  wire [61:0] span_prod = span_reg * per_reg;
  assign sweep_on = wave_reg != 2'(WAVE_DC) && span_reg != FREQ_RST
    && per_reg != 32'h00000000; // R4 R5 R6
  assign act_span = sweep_on ? span_prod[PHASE_W-1:0] : FREQ_RST; // R8
  assign act_per = sweep_on ? per_reg : 32'h00000000; // R8
  wire sw_wrap = sw_cnt_reg >= per_reg - 32'h00000001;
  wire [PHASE_W-1:0] freq_now = freq_reg + sw_ofs_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_ofs_reg <= FREQ_RST;
      sw_cnt_reg <= 32'h00000000;
    end else if (!sweep_on || (adv && sw_wrap)) begin
      sw_ofs_reg <= FREQ_RST; // R5 R6 R13
      sw_cnt_reg <= 32'h00000000;
    end else if (adv) begin
      sw_ofs_reg <= sw_ofs_reg + span_reg; // R13
      sw_cnt_reg <= sw_cnt_reg + 32'h00000001;
    end
  end

  // ----------------------------------------
  // nco and waveform
  // ----------------------------------------
  logic [PHASE_W-1:0] phase_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= FREQ_RST;
      bunch_reg <= 8'h00;
    end else if (adv) begin
      phase_reg <= phase_reg + freq_now; // R1
      bunch_reg <= (bunch_reg == LAST_BUNCH) ? 8'h00 : bunch_reg + 8'h01;
    end
  end

  wire [1:0] quad = phase_reg[PHASE_W-1:PHASE_W-2];
  wire [IDX_W-1:0] qidx = phase_reg[PHASE_W-3:PHASE_W-2-IDX_W];
  wire [IDX_W-1:0] tidx = quad[0] ? ~qidx : qidx;
  wire [SMP_W-1:0] smag = {1'b0, SINE_Q[tidx]};
  wire [SMP_W-1:0] sine_v = quad[1] ? SMP_W'(-smag) : smag;
  wire [SMP_W-1:0] sq_v = quad[1] ? FS_NEG : FS_POS;
  wire [SMP_W-1:0] wave_v = (wave_reg == 2'(WAVE_SINE)) ? sine_v :
    (wave_reg == 2'(WAVE_SQUARE)) ? sq_v : FS_POS; // R3
  wire signed [AMP_W+SMP_W:0] prod = $signed(wave_v) * $signed({1'b0, ampl_reg});
  wire [SMP_W-1:0] scaled = prod[AMP_SHIFT+SMP_W-1:AMP_SHIFT]; // R2
  wire [7:0] bword = bunch_reg >> 5;
  wire [31:0] mword = mask_mem[bword[$clog2(MASK_WORDS)-1:0]];
  wire en_bit = mword[bunch_reg[4:0]]; // R9 R11
  bdg_sample_s gen_s;
  assign gen_s.bunch = bunch_reg;
  assign gen_s.data = en_bit ? scaled : 16'h0000; // R12

  // ----------------------------------------
  // two-entry output buffer
  // ----------------------------------------
  // the nco only advances when its word enters the buffer, so a dac stall loses nothing
  bdg_sample_s ent0_reg;
  bdg_sample_s ent1_reg;
  logic [1:0] cnt_reg;
  wire pop = out_valid && out_ready;
  assign adv = cnt_reg != 2'h2 || pop;
  assign out_valid = cnt_reg != 2'h0;
  assign out_sample = ent0_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ent0_reg <= '0;
      ent1_reg <= '0;
      cnt_reg <= 2'h0;
    end else begin
      case (cnt_reg)
        2'h0: ent0_reg <= gen_s;
        2'h1: begin
          if (pop) ent0_reg <= gen_s;
          else ent1_reg <= gen_s;
        end
        2'h2: begin
          if (pop) begin
            ent0_reg <= ent1_reg;
            ent1_reg <= gen_s;
          end
        end
        default: ent0_reg <= ent0_reg;
      endcase
      cnt_reg <= (cnt_reg == 2'h0) ? 2'h1 : (cnt_reg == 2'h1 && !pop) ? 2'h2 : cnt_reg;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_phase_step;
    @(posedge pclk) disable iff (!presetn)
      adv |=> phase_reg == $past(phase_reg) + $past(freq_now);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("nco step wrong"); // R1

  property p_amp_zero;
    @(posedge pclk) disable iff (!presetn)
      ampl_reg == AMP_RST |-> scaled == 16'h0000;
  endproperty
  a_amp_zero: assert property (p_amp_zero) else $error("zero amplitude leaks"); // R2

  property p_dc_level;
    @(posedge pclk) disable iff (!presetn)
      wave_reg == 2'(WAVE_DC) && ampl_reg == AMP_FULL && en_bit |-> gen_s.data == FS_POS;
  endproperty
  a_dc_level: assert property (p_dc_level) else $error("dc level wrong"); // R3

  property p_dc_no_sweep;
    @(posedge pclk) disable iff (!presetn)
      wave_reg == 2'(WAVE_DC) |=> sw_ofs_reg == FREQ_RST;
  endproperty
  a_dc_no_sweep: assert property (p_dc_no_sweep) else $error("dc swept"); // R4

  property p_span_zero;
    @(posedge pclk) disable iff (!presetn)
      span_reg == FREQ_RST |=> freq_now == freq_reg;
  endproperty
  a_span_zero: assert property (p_span_zero) else $error("zero span modulates"); // R5

  property p_per_zero;
    @(posedge pclk) disable iff (!presetn)
      per_reg == 32'h00000000 |-> !sweep_on && act_per == 32'h00000000 ##1 sw_ofs_reg == FREQ_RST;
  endproperty
  a_per_zero: assert property (p_per_zero) else $error("zero period modulates"); // R6

  property p_act_freq;
    @(posedge pclk) disable iff (!presetn)
      wr && paddr == OFS_FREQ |=> freq_reg == $past(pwdata[PHASE_W-1:0]);
  endproperty
  a_act_freq: assert property (p_act_freq) else $error("freq not loaded"); // R7

  property p_masked_zero;
    @(posedge pclk) disable iff (!presetn)
      !en_bit |-> gen_s.data == 16'h0000;
  endproperty
  a_masked_zero: assert property (p_masked_zero) else $error("masked bunch driven"); // R12

  property p_sweep_restart;
    @(posedge pclk) disable iff (!presetn)
      sweep_on && adv && sw_wrap |=> sw_ofs_reg == FREQ_RST && sw_cnt_reg == 32'h00000000;
  endproperty
  a_sweep_restart: assert property (p_sweep_restart) else $error("sweep no restart"); // R13

  property p_hold_stall;
    @(posedge pclk) disable iff (!presetn)
      out_valid && !out_ready |=> out_valid && out_sample == $past(out_sample);
  endproperty
  a_hold_stall: assert property (p_hold_stall) else $error("stalled word changed"); // R9

  property p_act_span;
    @(posedge pclk) disable iff (!presetn)
      sweep_on |-> act_span == PHASE_W'(span_reg * per_reg) && act_per == per_reg;
  endproperty
  a_act_span: assert property (p_act_span) else $error("actual span wrong"); // R8

  property p_dc_off;
    @(posedge pclk) disable iff (!presetn)
      wave_reg == 2'(WAVE_DC) |-> !sweep_on && act_span == FREQ_RST && act_per == 32'h00000000;
  endproperty
  a_dc_off: assert property (p_dc_off) else $error("dc sweep reported"); // R4

  property p_span_off;
    @(posedge pclk) disable iff (!presetn)
      span_reg == FREQ_RST |-> !sweep_on && act_span == FREQ_RST && act_per == 32'h00000000;
  endproperty
  a_span_off: assert property (p_span_off) else $error("zero span reported active"); // R5

  property p_sweep_step;
    @(posedge pclk) disable iff (!presetn)
      sweep_on && adv && !sw_wrap |=> sw_ofs_reg == $past(sw_ofs_reg) + $past(span_reg)
        && sw_cnt_reg == $past(sw_cnt_reg) + 32'h00000001;
  endproperty
  a_sweep_step: assert property (p_sweep_step) else $error("sweep step wrong"); // R13

  property p_mask_write;
    @(posedge pclk) disable iff (!presetn)
      wr && in_mask |=> mask_mem[$past(mask_idx[$clog2(MASK_WORDS)-1:0])] == $past(pwdata);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask word not stored"); // R10 R11

  property p_square_level;
    @(posedge pclk) disable iff (!presetn)
      wave_reg == 2'(WAVE_SQUARE) && ampl_reg == AMP_FULL && en_bit
        |-> gen_s.data == FS_POS || gen_s.data == FS_NEG;
  endproperty
  a_square_level: assert property (p_square_level) else $error("square level wrong"); // R3 R9

  property p_setting_range;
    @(posedge pclk) disable iff (!presetn)
      ampl_reg <= AMP_FULL && wave_reg <= 2'(WAVE_DC);
  endproperty
  a_setting_range: assert property (p_setting_range) else $error("bad setting"); // R2 R3

  property p_gen_freeze;
    @(posedge pclk) disable iff (!presetn)
      !adv |=> $stable(phase_reg) && $stable(bunch_reg);
  endproperty
  a_gen_freeze: assert property (p_gen_freeze) else $error("generator ran while stalled"); // R1

  property p_bunch_wrap;
    @(posedge pclk) disable iff (!presetn)
      adv && bunch_reg == LAST_BUNCH |=> bunch_reg == 8'h00;
  endproperty
  a_bunch_wrap: assert property (p_bunch_wrap) else $error("bunch did not wrap"); // R9 R11

  property p_act_freq_read;
    @(posedge pclk) disable iff (!presetn)
      acc && !pwrite && paddr == OFS_ACT_FREQ |-> prdata == 32'(freq_reg) && !pslverr;
  endproperty
  a_act_freq_read: assert property (p_act_freq_read) else $error("actual freq misread"); // R7

  property p_stream_on;
    @(posedge pclk) disable iff (!presetn)
      out_valid |=> out_valid;
  endproperty
  a_stream_on: assert property (p_stream_on) else $error("output stream ran dry"); // R9
endmodule
`default_nettype wire

// >>> bdg_dac_model.sv
/*
  dac-side sink model for the drive stream: answers with ready, promptly or with stalls.
  assumes the bench seeds the generator and drives slow and hold off the clock edge.
*/
`default_nettype none
module bdg_dac_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic hold,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // ready pattern
  // ----------------------------------------
  // hold stalls for long so the two-entry buffer fills; slow stalls at random
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !hold && (!slow || $urandom_range(0, 1) == 1);
    end
  end
endmodule
`default_nettype wire

// >>> test_bunch_drive_excitation_generator.sv
/*
  self-checking bench: apb settings and readback, sweep readback, output stream and stall.
  assumes the dac model beside it and NUM_BUNCH of 40, two mask words.
*/
`default_nettype none
module test_bunch_drive_excitation_generator;
  timeunit 1ns;
  timeprecision 1ns;
  import bdg_pkg::*;
  localparam int NB = 40;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, out_valid, out_ready;
  logic slow, hold, mon_on, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, s, p;
  logic [16:0] amp;
  logic [1:0] wv;
  logic [63:0] mk;
  logic [7:0] last_b;
  int failures, checks_done, cyc;
  bdg_sample_s out_sample, held;
  logic [11:0] regs [8] = '{OFS_CTRL, OFS_FREQ, OFS_AMPL, OFS_SPAN, OFS_PER, OFS_ACT_FREQ,
    OFS_ACT_SPAN, OFS_ACT_PER};
  bdg_drive_gen #(.NUM_BUNCH(NB)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .out_valid(out_valid), .out_ready(out_ready),
    .out_sample(out_sample));
  bdg_dac_model dac_u (.pclk(pclk), .presetn(presetn), .slow(slow), .hold(hold),
    .out_ready(out_ready));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic sweep(input logic [31:0] w, sp, pr, es, ep);
    apb(1'b1, OFS_CTRL, w);
    apb(1'b1, OFS_SPAN, sp);
    apb(1'b1, OFS_PER, pr);
    rchk(OFS_ACT_SPAN, es);
    rchk(OFS_ACT_PER, ep);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(32'(rd[8]), 32'(es != 0));
  endtask
  // phase sits at zero after reset with no tuning, so sine shows its first table entry
  function automatic logic [15:0] ed(input logic en);
    logic [31:0] lv;
    lv = (wv == 2'h0) ? 32'(SINE_Q[0]) : 32'(FS_POS);
    return en ? 16'((lv * 32'(amp)) >> 15) : 16'h0;
  endfunction
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // stream monitor and timeout
  // ----------------------------------------
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      close_out();
    end
    if (mon_on && out_valid === 1'b1 && out_ready === 1'b1) begin
      chk(32'(out_sample.data), 32'(ed(mk[out_sample.bunch])));
      if (last_b != 8'hFF) chk(32'(out_sample.bunch), 32'((last_b + 1) % NB));
      last_b <= out_sample.bunch;
    end
  end
  initial begin
    {psel, penable, pwrite, slow, hold, mon_on, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    amp = '0;
    wv = '0;
    mk = '0;
    last_b = 8'hFF;
    s = $urandom(42911);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) rchk(regs[i], 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    s = $urandom();
    apb(1'b1, OFS_FREQ, s);
    apb(1'b1, OFS_ACT_FREQ, 32'h0);
    rchk(OFS_ACT_FREQ, s & 32'h3FFFFFFF);
    apb(1'b1, OFS_AMPL, 32'h1FFFF);
    rchk(OFS_AMPL, 32'h8000);
    apb(1'b1, OFS_CTRL, 32'h3);
    rchk(OFS_CTRL, 32'h2);
    $display("register test done");
    s = $urandom_range(1, 255);
    p = $urandom_range(1, 255);
    sweep(0, s, p, (s * p) & 32'h3FFFFFFF, p);
    sweep(1, 3, 5, 15, 5);
    sweep(2, 3, 5, 0, 0);
    sweep(0, 0, 5, 0, 0);
    sweep(0, 3, 0, 0, 0);
    $display("sweep test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_ACT_SPAN, 32'h0);
    $display("reset test done");
    mk = {$urandom(), $urandom()};
    apb(1'b1, OFS_FREQ, 32'h0);
    apb(1'b1, OFS_MASK, mk[31:0]);
    apb(1'b1, OFS_MASK + 12'h4, mk[63:32]);
    rchk(OFS_MASK, mk[31:0]);
    apb(1'b0, OFS_MASK + 12'h4, 32'h0);
    chk(rd & 32'hFF, 32'(mk[39:32]));
    for (int i = 0; i < 6; i++) begin
      mon_on = 1'b0;
      wv = 2'(i % 3);
      amp = (i == 0) ? 17'h0 : (i < 3) ? 17'h08000 : 17'($urandom_range(0, 32768));
      apb(1'b1, OFS_CTRL, 32'(wv));
      apb(1'b1, OFS_AMPL, 32'(amp));
      slow <= (i > 2);
      // stale words from the old settings must drain before checking
      repeat (30) @(posedge pclk);
      last_b = 8'hFF;
      mon_on = 1'b1;
      repeat (150) @(posedge pclk);
      $display("stream test %0d done", i);
    end
    hold <= 1'b1;
    repeat (6) @(posedge pclk);
    held = out_sample;
    repeat (20) @(posedge pclk);
    chk(32'(out_valid), 32'h1);
    chk(32'(out_sample), 32'(held));
    hold <= 1'b0;
    repeat (100) @(posedge pclk);
    $display("stall test done");
    close_out();
  end
endmodule
`default_nettype wire
